// [src/cod_map.svh]
`ifndef COD_MAP_SVH
`define COD_MAP_SVH
// condition flag bit positions
`define COD_CC_V 7
`define COD_CC_H 4
`define COD_CC_I 3
`define COD_CC_N 2
`define COD_CC_Z 1
`define COD_CC_C 0
// opcode values with special handling
`define COD_OP_PREFIX 8'h9e
`define COD_OP_TSX 8'h95
`define COD_OP_TXS 8'h94
`define COD_OP_TXA 8'h9f
`define COD_OP_TSTA 8'h4d
`define COD_OP_TSTX 8'h5d
`define COD_LO_TEST 4'hd
`define COD_LO_MOVE 4'he
// restart vector after an undefined opcode
`define COD_RESET_VEC 16'hfffe
// cycle counts
`define COD_CYC_BITBR 4'h5
`define COD_CYC_BSET 4'h4
`define COD_CYC_BRANCH 4'h3
`define COD_CYC_XFER 4'h2
`define COD_CYC_DD 4'h5
`define COD_CYC_MOVE 4'h4
`define COD_CYC_COMPARE_BRANCH_EQUAL 4'h5
`define COD_CYC_COMPARE_BRANCH_EQUAL_IX 4'h4
`define COD_CYC_MEMTEST 4'h3
// reset value of the captured opcode and operand bytes
`define COD_RST_BYTE 8'h00
`endif

// [src/cod_pkg.sv]
package cod_pkg;
    // operand addressing forms
    typedef enum logic [4:0] {
        md_inh = 5'h00, md_imm = 5'h01, md_imm16 = 5'h02, md_dir = 5'h03,
        md_abs16 = 5'h04, md_idx = 5'h05, md_idx8 = 5'h06, md_idx16 = 5'h07,
        md_stk8 = 5'h08, md_stk16 = 5'h09, md_branch = 5'h0a, md_dir_br = 5'h0b,
        md_imm_br = 5'h0c, md_idx8_br = 5'h0d, md_idx_br = 5'h0e, md_stk8_br = 5'h0f,
        md_idx8inc_br = 5'h10, md_idxinc_br = 5'h11, md_dir_dir = 5'h12,
        md_imm_dir = 5'h13, md_dir_idxinc = 5'h14, md_idxinc_dir = 5'h15
    } cod_mode_type;
    // fetch sequencer states
    typedef enum logic [1:0] {
        st_idle = 2'b00, st_prefix = 2'b01, st_operand = 2'b10, st_issue = 2'b11
    } cod_state_type;
    // decoded instruction handed to the datapath
    typedef struct packed {
        logic         valid;
        logic         prefixed;
        logic [7:0]   opcode;
        logic [3:0]   group;
        logic [3:0]   op_sel;
        cod_mode_type mode;
        logic [2:0]   len;
        logic [3:0]   cycles;
        logic [15:0]  ea;
        logic [15:0]  src_ea;
        logic [15:0]  dst_ea;
        logic [7:0]   imm;
        logic [7:0]   relative_mode;
        logic         hx_we;
        logic [15:0]  hx_new;
        logic         sp_we;
        logic [15:0]  sp_new;
        logic         cc_we;
        logic [7:0]   cc_flags;
    } cod_dec_type;
endpackage : cod_pkg

// [src/cod_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cod_map.svh"
// Functional notes
// RULE1: test sets N,Z, clears V, keeps others
// RULE2: 16-bit index offset, high byte first
// RULE3: extended address two bytes, high first
// RULE4: bit-test branch: 3 bytes, 5 cycles
// RULE5: direct to index, then index increments
// RULE6: index to direct, then index increments
// RULE7: immediate stored to direct, 3 bytes
// RULE8: direct to direct copy, 3 bytes
// RULE9: index plus offset, then index increments
// RULE10: index address, increment after access
// RULE11: prefix swaps index for stack pointer
// RULE12: stack pointer plus eight-bit offset
// RULE13: stack pointer plus sixteen-bit offset
// RULE14: one offset byte added to index
// RULE15: branch: 2 bytes, 3 cycles always (the code gives branch opcode ad 2 cycles)
// RULE16: high digit group, low digit operation
// RULE17: stack/index transfers, 2 cycles, flags kept
// RULE18: undefined opcode restarts at reset vector
module cod_decoder (
    input  wire logic            clk_i,         // bus clock
    input  wire logic            rst_i,         // synchronous reset
    input  wire logic            ce_i,          // clock enable
    input  wire logic            fetch_valid_i, // program byte offered
    input  wire logic [7:0]      fetch_byte_i,  // program byte
    output logic                 fetch_ready_o, // byte taken when valid
    input  wire logic [7:0]      acc_i,         // accumulator
    input  wire logic [15:0]     hx_i,          // combined index register
    input  wire logic [15:0]     sp_i,          // stack pointer
    input  wire logic [7:0]      cc_i,          // condition flags
    input  wire logic [7:0]      mem_data_i,    // memory operand for tests
    output var cod_pkg::cod_dec_type dec_o,     // decoded instruction
    output logic                 illegal_o,     // internal reset request
    output logic [15:0]          restart_o      // vector after that reset
);
    cod_pkg::cod_state_type state;      // sequencer state
    cod_pkg::cod_state_type next_state; // its next value
    logic [7:0]  opc;                   // captured opcode
    logic        pre;                   // prefix byte seen
    logic [7:0]  b1;                    // first operand byte
    logic [7:0]  b2;                    // second operand byte
    logic [1:0]  need;                  // operand bytes the opcode needs in total
    logic [1:0]  got;                   // operand bytes fetched
    logic        take;                  // byte accepted this cycle
    cod_pkg::cod_mode_type mode;        // mode of captured opcode
    cod_pkg::cod_mode_type fmode;       // mode of byte being fetched
    cod_pkg::cod_dec_type  next_dec;    // decode result at issue
    logic [7:0]  tval;                  // value under test
    logic        is_test;               // test family opcode

    // addressing form from opcode and prefix
    function automatic cod_pkg::cod_mode_type mode_f(input logic [7:0] o, input logic p);
        logic [3:0] h;
        logic [3:0] l;
        h = o[7:4];
        l = o[3:0];
        mode_f = cod_pkg::md_inh;
        // RULE16: group by high digit
        if (p)
        begin
            // RULE11: stack pointer replaces index
            if (h == 4'h6)
                mode_f = (l == 4'h1 || l == 4'hb) ? cod_pkg::md_stk8_br : cod_pkg::md_stk8;
            else if (h == 4'he)
                mode_f = cod_pkg::md_stk8;
            else
                mode_f = cod_pkg::md_stk16;
        end
        else
        begin
            case (h)
                4'h0: mode_f = cod_pkg::md_dir_br;
                4'h1: mode_f = cod_pkg::md_dir;
                4'h2: mode_f = cod_pkg::md_branch;
                4'h3: mode_f = (l == 4'h1 || l == 4'hb) ? cod_pkg::md_dir_br : cod_pkg::md_dir;
                4'h4:
                begin
                    if (l == `COD_LO_MOVE) mode_f = cod_pkg::md_dir_dir;
                    else if (l == 4'h1) mode_f = cod_pkg::md_imm_br;
                    else if (l == 4'h5) mode_f = cod_pkg::md_imm16;
                    else mode_f = cod_pkg::md_inh;
                end
                4'h5:
                begin
                    if (l == `COD_LO_MOVE) mode_f = cod_pkg::md_dir_idxinc;
                    else if (l == 4'h5) mode_f = cod_pkg::md_dir;
                    else mode_f = cod_pkg::md_inh;
                end
                4'h6:
                begin
                    if (l == `COD_LO_MOVE) mode_f = cod_pkg::md_imm_dir;
                    else if (l == 4'h1) mode_f = cod_pkg::md_idx8inc_br;
                    else if (l == 4'hb) mode_f = cod_pkg::md_idx8_br;
                    else if (l == 4'h5) mode_f = cod_pkg::md_imm16;
                    else if (l == 4'h2) mode_f = cod_pkg::md_inh;
                    else mode_f = cod_pkg::md_idx8;
                end
                4'h7:
                begin
                    if (l == `COD_LO_MOVE) mode_f = cod_pkg::md_idxinc_dir;
                    else if (l == 4'h1) mode_f = cod_pkg::md_idxinc_br;
                    else if (l == 4'hb) mode_f = cod_pkg::md_idx_br;
                    else if (l == 4'h5) mode_f = cod_pkg::md_dir;
                    else if (l == 4'h2) mode_f = cod_pkg::md_inh;
                    else mode_f = cod_pkg::md_idx;
                end
                4'h8: mode_f = cod_pkg::md_inh;
                4'h9: mode_f = (l < 4'h4) ? cod_pkg::md_branch : cod_pkg::md_inh;
                4'ha: mode_f = (l == 4'hd) ? cod_pkg::md_branch : cod_pkg::md_imm;
                4'hb: mode_f = cod_pkg::md_dir;
                4'hc: mode_f = cod_pkg::md_abs16;
                4'hd: mode_f = cod_pkg::md_idx16;
                4'he: mode_f = cod_pkg::md_idx8;
                default: mode_f = cod_pkg::md_idx;
            endcase
        end
    endfunction : mode_f

    // operand bytes that follow the opcode
    function automatic logic [1:0] opn_f(input cod_pkg::cod_mode_type m);
        case (m)
            cod_pkg::md_inh, cod_pkg::md_idx: opn_f = 2'h0;
            cod_pkg::md_imm, cod_pkg::md_dir, cod_pkg::md_idx8, cod_pkg::md_stk8,
            cod_pkg::md_branch, cod_pkg::md_idx_br, cod_pkg::md_idxinc_br,
            cod_pkg::md_dir_idxinc, cod_pkg::md_idxinc_dir: opn_f = 2'h1;
            default: opn_f = 2'h2;
        endcase
    endfunction : opn_f

    // opcodes with no defined meaning
    function automatic logic legal_f(input logic [7:0] o, input logic p);
        if (p)
            legal_f = (o[7:4] == 4'h6 && o[3:0] != 4'h2 && o[3:0] != 4'h5 && o[3:0] != 4'he)
                   || ((o[7:4] == 4'hd || o[7:4] == 4'he) && o[3:0] != 4'hc && o[3:0] != 4'hd);
        else
            legal_f = !(o == 8'h32 || o == 8'h3e || o == 8'h82 || o == 8'h8d
                     || o == 8'h96 || o == 8'hac);
    endfunction : legal_f

    // base cycle count, one extra for the prefix
    function automatic logic [3:0] cyc_f(input logic [7:0] o, input logic p);
        logic [3:0] c;
        case (o[7:4])
            4'h0: c = `COD_CYC_BITBR;
            4'h1: c = `COD_CYC_BSET;
            4'h2: c = `COD_CYC_BRANCH;
            4'h3: c = (o[3:0] == `COD_LO_TEST) ? 4'h3 : 4'h4;
            4'h4, 4'h5: c = 4'h1;
            4'h6: c = (o[3:0] == `COD_LO_TEST) ? 4'h3 : 4'h4;
            4'h7: c = (o[3:0] == `COD_LO_TEST) ? 4'h2 : 4'h3;
            4'h8, 4'h9, 4'ha: c = 4'h2;
            4'hb, 4'he: c = 4'h3;
            4'hc, 4'hd: c = 4'h4;
            default: c = 4'h2;
        endcase
        // fixed counts for special forms
        if (o[3:0] == 4'h1 && (o[7:4] == 4'h3 || o[7:4] == 4'h6)) c = `COD_CYC_COMPARE_BRANCH_EQUAL;
        if (o == 8'h41 || o == 8'h71) c = `COD_CYC_COMPARE_BRANCH_EQUAL_IX;
        if (o == 8'h4e) c = `COD_CYC_DD;
        if (o == 8'h5e || o == 8'h6e || o == 8'h7e) c = `COD_CYC_MOVE;
        if (o[7:4] == 4'h9 && o[3:0] < 4'h4) c = `COD_CYC_BRANCH;
        if (o == `COD_OP_TSX || o == `COD_OP_TXS) c = `COD_CYC_XFER;
        if (o == `COD_OP_TXA || o[7:4] == 4'h9 && o[3:0] > 4'h7) c = 4'h1;
        cyc_f = c + {3'h0, p};
    endfunction : cyc_f

    assign fmode = mode_f(fetch_byte_i, state == cod_pkg::st_prefix);
    assign take = fetch_valid_i && fetch_ready_o && ce_i;
    assign mode = mode_f(opc, pre);
    // handshake: bytes are only refused while issuing
    assign fetch_ready_o = (state != cod_pkg::st_issue);

    // sequencer next state
    always_comb
    begin
        next_state = state;
        case (state)
            cod_pkg::st_idle, cod_pkg::st_prefix:
            begin
                if (take)
                begin
                    // RULE18: undefined opcode aborts
                    if (!legal_f(fetch_byte_i, state == cod_pkg::st_prefix))
                        next_state = cod_pkg::st_idle;
                    else if (state == cod_pkg::st_idle && fetch_byte_i == `COD_OP_PREFIX)
                        next_state = cod_pkg::st_prefix;
                    else if (opn_f(fmode) == 2'h0)
                        next_state = cod_pkg::st_issue;
                    else
                        next_state = cod_pkg::st_operand;
                end
            end
            cod_pkg::st_operand:
                if (take && got + 2'h1 == need) next_state = cod_pkg::st_issue;
            cod_pkg::st_issue: next_state = cod_pkg::st_idle;
            default: next_state = cod_pkg::st_idle;
        endcase
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i) state <= cod_pkg::st_idle;
        else if (ce_i) state <= next_state;
    end

    // opcode and operand byte capture
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            opc  <= `COD_RST_BYTE;
            pre  <= 1'b0;
            b1   <= `COD_RST_BYTE;
            b2   <= `COD_RST_BYTE;
            need <= 2'h0;
            got  <= 2'h0;
        end
        else if (take)
        begin
            if (state == cod_pkg::st_idle)
            begin
                // first byte: opcode or prefix
                opc  <= fetch_byte_i;
                pre  <= (fetch_byte_i == `COD_OP_PREFIX);
                need <= opn_f(fmode);
                got  <= 2'h0;
            end
            else if (state == cod_pkg::st_prefix)
            begin
                // opcode after the prefix
                opc  <= fetch_byte_i;
                need <= opn_f(fmode);
                got  <= 2'h0;
            end
            else if (state == cod_pkg::st_operand)
            begin
                // RULE2: high byte arrives first
                if (got == 2'h0) b1 <= fetch_byte_i;
                else b2 <= fetch_byte_i;
                got <= got + 2'h1;
            end
        end
    end

    // value and family for the test instructions
    assign is_test = (opc[3:0] == `COD_LO_TEST) && (pre ? opc[7:4] == 4'h6
                   : (opc[7:4] >= 4'h3 && opc[7:4] <= 4'h7));
    assign tval = (!pre && opc == `COD_OP_TSTA) ? acc_i
                : (!pre && opc == `COD_OP_TSTX) ? hx_i[7:0] : mem_data_i;

    // decode result built from captured bytes
    always_comb
    begin
        next_dec          = '0;
        next_dec.valid    = 1'b1;
        next_dec.prefixed = pre;
        next_dec.opcode   = opc;
        // RULE16: group and operation digits
        next_dec.group    = opc[7:4];
        next_dec.op_sel   = opc[3:0];
        next_dec.mode     = mode;
        next_dec.len      = 3'h1 + {2'h0, pre} + {1'b0, need};
        next_dec.cycles   = cyc_f(opc, pre);
        next_dec.hx_new   = hx_i;
        next_dec.sp_new   = sp_i;
        next_dec.cc_flags = cc_i;
        case (mode)
            cod_pkg::md_imm: next_dec.imm = b1;
            cod_pkg::md_imm16: next_dec.ea = {b1, b2};
            cod_pkg::md_dir: next_dec.ea = {8'h00, b1};
            // RULE3: absolute address high then low
            cod_pkg::md_abs16: next_dec.ea = {b1, b2};
            // RULE2: sixteen-bit offset on index
            cod_pkg::md_idx16: next_dec.ea = hx_i + {b1, b2};
            // RULE14: one offset byte on index
            cod_pkg::md_idx8: next_dec.ea = hx_i + {8'h00, b1};
            cod_pkg::md_idx: next_dec.ea = hx_i;
            // RULE12: stack plus eight-bit offset
            cod_pkg::md_stk8: next_dec.ea = sp_i + {8'h00, b1};
            // RULE13: stack plus sixteen-bit offset
            cod_pkg::md_stk16: next_dec.ea = sp_i + {b1, b2};
            // RULE15: one offset byte
            cod_pkg::md_branch: next_dec.relative_mode = b1;
            // RULE4: direct operand then branch offset
            cod_pkg::md_dir_br:
            begin
                next_dec.ea  = {8'h00, b1};
                next_dec.relative_mode = b2;
            end
            cod_pkg::md_imm_br:
            begin
                next_dec.imm = b1;
                next_dec.relative_mode = b2;
            end
            cod_pkg::md_idx8_br:
            begin
                next_dec.ea  = hx_i + {8'h00, b1};
                next_dec.relative_mode = b2;
            end
            cod_pkg::md_stk8_br:
            begin
                next_dec.ea  = sp_i + {8'h00, b1};
                next_dec.relative_mode = b2;
            end
            cod_pkg::md_idx_br:
            begin
                next_dec.ea  = hx_i;
                next_dec.relative_mode = b1;
            end
            // RULE9: offset address, index then bumped
            cod_pkg::md_idx8inc_br:
            begin
                next_dec.ea     = hx_i + {8'h00, b1};
                next_dec.relative_mode    = b2;
                next_dec.hx_we  = 1'b1;
                next_dec.hx_new = hx_i + 16'h0001;
            end
            // RULE10: index address, then bumped
            cod_pkg::md_idxinc_br:
            begin
                next_dec.ea     = hx_i;
                next_dec.relative_mode    = b1;
                next_dec.hx_we  = 1'b1;
                next_dec.hx_new = hx_i + 16'h0001;
            end
            // RULE8: two direct addresses
            cod_pkg::md_dir_dir:
            begin
                next_dec.src_ea = {8'h00, b1};
                next_dec.dst_ea = {8'h00, b2};
            end
            // RULE7: immediate then destination
            cod_pkg::md_imm_dir:
            begin
                next_dec.imm    = b1;
                next_dec.dst_ea = {8'h00, b2};
            end
            // RULE5: direct source into index target
            cod_pkg::md_dir_idxinc:
            begin
                next_dec.src_ea = {8'h00, b1};
                next_dec.dst_ea = hx_i;
                next_dec.hx_we  = 1'b1;
                next_dec.hx_new = hx_i + 16'h0001;
            end
            // RULE6: index source into direct target
            cod_pkg::md_idxinc_dir:
            begin
                next_dec.src_ea = hx_i;
                next_dec.dst_ea = {8'h00, b1};
                next_dec.hx_we  = 1'b1;
                next_dec.hx_new = hx_i + 16'h0001;
            end
            default: next_dec.ea = 16'h0000;
        endcase
        // RULE17: stack and index transfers
        if (!pre && opc == `COD_OP_TSX)
        begin
            next_dec.hx_we  = 1'b1;
            next_dec.hx_new = sp_i + 16'h0001;
        end
        if (!pre && opc == `COD_OP_TXS)
        begin
            next_dec.sp_we  = 1'b1;
            next_dec.sp_new = hx_i - 16'h0001;
        end
        // RULE1: flags of the test family
        if (is_test)
        begin
            next_dec.cc_we               = 1'b1;
            next_dec.cc_flags[`COD_CC_V] = 1'b0;
            next_dec.cc_flags[`COD_CC_N] = tval[7];
            next_dec.cc_flags[`COD_CC_Z] = (tval == 8'h00);
        end
    end

    // decode output register, valid for one enabled cycle, held while ce_i is low
    always_ff @(posedge clk_i)
    begin
        if (rst_i) dec_o <= '0;
        else if (ce_i)
        begin
            if (state == cod_pkg::st_issue) dec_o <= next_dec;
            else dec_o.valid <= 1'b0;
        end
    end

    // RULE18: internal reset on undefined opcode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            illegal_o <= 1'b0;
            restart_o <= `COD_RESET_VEC;
        end
        else if (ce_i)
        begin
            illegal_o <= take && (state == cod_pkg::st_idle || state == cod_pkg::st_prefix)
                      && !legal_f(fetch_byte_i, state == cod_pkg::st_prefix);
            restart_o <= `COD_RESET_VEC;
        end
    end

    // checks on the decode output
    test_flags_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
        $rose(dec_o.valid) && dec_o.cc_we |-> !dec_o.cc_flags[`COD_CC_V]
        && dec_o.cc_flags[`COD_CC_C] == $past(cc_i[`COD_CC_C])
        && dec_o.cc_flags[`COD_CC_I] == $past(cc_i[`COD_CC_I]))
        else $error("test flags wrong");
    abs_order_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
        $rose(dec_o.valid) && dec_o.mode == cod_pkg::md_abs16
        |-> dec_o.ea == {$past(b1), $past(b2)})
        else $error("absolute address order wrong");
    bitbr_size_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
        $rose(dec_o.valid) && dec_o.group == 4'h0 |-> dec_o.len == 3'h3 && dec_o.cycles == 4'h5)
        else $error("bit branch size wrong");
    dir_idx_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        $rose(dec_o.valid) && dec_o.mode == cod_pkg::md_dir_idxinc
        |-> dec_o.dst_ea == $past(hx_i) && dec_o.hx_new == $past(hx_i) + 16'h0001
        && dec_o.len == 3'h2)
        else $error("direct to index move wrong");
    idx_dir_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        $rose(dec_o.valid) && dec_o.mode == cod_pkg::md_idxinc_dir
        |-> dec_o.src_ea == $past(hx_i) && dec_o.hx_we && dec_o.cycles == 4'h4)
        else $error("index to direct move wrong");
    stk_offset_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
        $rose(dec_o.valid) && dec_o.mode == cod_pkg::md_stk8
        |-> dec_o.prefixed && dec_o.ea == $past(sp_i) + {8'h00, $past(b1)})
        else $error("stack offset address wrong");
    branch_size_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE15
        $rose(dec_o.valid) && dec_o.group == 4'h2 |-> dec_o.len == 3'h2 && dec_o.cycles == 4'h3)
        else $error("branch size wrong");
    digit_split_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
        dec_o.valid |-> {dec_o.group, dec_o.op_sel} == dec_o.opcode)
        else $error("opcode split wrong");
    xfer_tsx_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
        $rose(dec_o.valid) && !dec_o.prefixed && dec_o.opcode == `COD_OP_TSX
        |-> dec_o.hx_new == $past(sp_i) + 16'h0001 && dec_o.cycles == 4'h2 && !dec_o.cc_we)
        else $error("stack to index transfer wrong");
    illegal_abort_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
        illegal_o |-> state == cod_pkg::st_idle && restart_o == `COD_RESET_VEC && !dec_o.valid)
        else $error("undefined opcode not aborted");
endmodule : cod_decoder
`default_nettype wire

// [testbench/cod_prog_mem.sv]
`timescale 1ns/1ps
`default_nettype none
// program memory: offers queued bytes, moves on only when one is taken
module cod_prog_mem (
    input  wire logic       clk_i,   // bus clock
    input  wire logic       rst_i,   // reset
    input  wire logic       ready_i, // decoder can take a byte
    input  wire logic       ce_i,    // clock enable
    output logic            valid_o, // byte offered
    output logic [7:0]      byte_o   // program byte
);
    logic [7:0] q[$]; // bytes still to offer
    // queue one byte
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask : push
    initial
    begin
        valid_o = 1'b0;
        byte_o = 8'h00;
    end
    // drop the taken byte, then drive just after the edge; the idle byte line toggles
    always @(posedge clk_i)
    begin
        if (valid_o && ready_i && ce_i && !rst_i) void'(q.pop_front());
        #1;
        valid_o <= (q.size() > 0);
        byte_o <= (q.size() > 0) ? q[0] : ~byte_o;
    end
endmodule : cod_prog_mem
`default_nettype wire

// [testbench/cpu_opcode_decode_addressing_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_opcode_decode_addressing_tb;
    logic clk_i = 0, rst_i = 1, ce_i = 1, fv, fr, ill;
    logic [7:0] fb, acc_i = 0, cc_i = 0, mem_i = 0, op;
    logic [15:0] hx_i = 0, sp_i = 0, rv;
    logic [31:0] r;
    logic [47:0] bad = 48'h323e828d96ac; // undefined opcodes
    cod_pkg::cod_dec_type d;
    integer seed = 32'h34c2, n_mismatch = 0, cmp_count = 0, i;
    cod_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .fetch_valid_i(fv),
        .fetch_byte_i(fb), .fetch_ready_o(fr), .acc_i(acc_i), .hx_i(hx_i), .sp_i(sp_i),
        .cc_i(cc_i), .mem_data_i(mem_i), .dec_o(d), .illegal_o(ill), .restart_o(rv));
    cod_prog_mem pm (.clk_i(clk_i), .rst_i(rst_i), .ready_i(fr), .ce_i(ce_i),
        .valid_o(fv), .byte_o(fb));
    // expected flags after a test: v cleared, n and z from value
    function automatic logic [15:0] tf(input logic [7:0] v);
        return {8'h00, 1'b0, cc_i[6:3], v[7], v == 8'h00, cc_i[0]};
    endfunction : tf
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    // random register state, queue n bytes, wait for decode or abort
    task automatic run(input int n, input logic [31:0] bs);
        int k;
        @(posedge clk_i);
        #1;
        acc_i = $random(seed);
        hx_i = $random(seed);
        sp_i = $random(seed);
        cc_i = $random(seed);
        mem_i = $random(seed);
        op = (bs[31:24] == 8'h9e) ? bs[23:16] : bs[31:24];
        for (k = 0; k < n; k++) pm.push(bs[31-8*k -: 8]);
        for (k = 0; k < 60; k++)
        begin
            @(posedge clk_i);
            #2;
            if (d.valid === 1'b1 || ill === 1'b1) break;
        end
        if (k == 60)
        begin
            n_mismatch++;
            $display("[FAIL] %0t decode never came", $time);
            give_verdict();
        end
        if (d.valid === 1'b1) chk({d.group, d.op_sel}, op);
        $display("test %h done", bs);
    endtask : run
    initial forever #5 clk_i = ~clk_i;
    initial
    begin
        repeat (16) @(posedge clk_i);
        #1 rst_i = 0;
        r = $random(seed);
        run(3, {8'hc6, r[15:0], 8'h00});
        chk(d.ea, r[15:0]);
        run(3, {8'hd6, r[15:0], 8'h00});
        chk(d.ea, {hx_i + r[15:0]});
        run(2, {8'h6d, r[7:0], 16'h0});
        chk(d.ea, {hx_i + r[7:0]});
        chk({d.len, d.cycles, 8'h00, d.cc_flags}, {3'h2, 4'h3, tf(mem_i)});
        run(3, {16'h9e6d, r[7:0], 8'h00});
        chk(d.ea, {sp_i + r[7:0]});
        chk({d.prefixed, d.len, d.cycles}, {1'b1, 3'h3, 4'h4});
        run(4, {16'h9ed6, r[15:0]});
        chk({d.ea, d.len, d.cycles}, {sp_i + r[15:0], 3'h4, 4'h5});
        run(1, 32'h4d000000);
        chk(d.cc_flags, tf(acc_i));
        run(1, 32'h5d000000);
        chk(d.cc_flags, tf(hx_i[7:0]));
        run(1, 32'h95000000);
        chk({d.hx_we, d.hx_new, d.cycles}, {1'b1, sp_i + 16'h1, 4'h2});
        run(1, 32'h94000000);
        chk({d.sp_we, d.sp_new, d.cycles}, {1'b1, hx_i - 16'h1, 4'h2});
        run(2, {8'h27, r[7:0], 16'h0});
        chk({d.relative_mode, d.len, d.cycles}, {r[7:0], 3'h2, 4'h3});
        run(3, {4'h0, r[19:16], r[15:0], 8'h00});
        chk({d.ea, d.relative_mode, d.len, d.cycles}, {8'h00, r[15:0], 3'h3, 4'h5});
        run(3, {8'h4e, r[15:0], 8'h00});
        chk({d.src_ea, d.dst_ea, d.len}, {8'h00, r[15:8], 8'h00, r[7:0], 3'h3});
        run(3, {8'h6e, r[15:0], 8'h00});
        chk({d.imm, d.dst_ea, d.cycles}, {r[15:8], 8'h00, r[7:0], 4'h4});
        run(2, {8'h5e, r[7:0], 16'h0});
        chk({d.src_ea, d.dst_ea, d.hx_new}, {8'h00, r[7:0], hx_i, hx_i + 16'h1});
        run(2, {8'h7e, r[7:0], 16'h0});
        chk({d.src_ea, d.dst_ea, d.hx_new}, {hx_i, 8'h00, r[7:0], hx_i + 16'h1});
        run(3, {8'h61, r[15:0], 8'h00});
        chk({d.ea, d.hx_new, d.cycles}, {hx_i + r[15:8], hx_i + 16'h1, 4'h5});
        run(2, {8'h71, r[7:0], 16'h0});
        chk({d.ea, d.hx_new, d.relative_mode}, {hx_i, hx_i + 16'h1, r[7:0]});
        // clock enable low: an offered byte must wait and the decode must hold
        @(posedge clk_i);
        #1 ce_i = 0;
        pm.push(8'h95);
        repeat (5) @(posedge clk_i);
        #2 chk({d.valid, ill, fr, d.opcode}, {3'b001, 8'h71});
        @(posedge clk_i);
        #1 ce_i = 1;
        run(0, 32'h95000000);
        chk({d.hx_we, d.hx_new}, {1'b1, sp_i + 16'h1});
        for (i = 0; i < 6; i++)
        begin
            run(1, {bad[47-8*i -: 8], 24'h0});
            chk({ill, rv}, {1'b1, 16'hfffe});
        end
        give_verdict();
    end
endmodule : cpu_opcode_decode_addressing_tb
`default_nettype wire
